/* hw/dps_pkg.sv */
// Package for the semaphore port controller: pin struct, commands, timing
package dps_pkg;
  localparam int          FLAG_COUNT    = 8;
  localparam int          IDX_W         = 3;
  localparam int          DATA_W        = 16;
  // Pin phase lengths in ns and cycles at 100 MHz
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          STROBE_NS     = 60;
  localparam int          GAP_NS        = 20;
  localparam int          STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 4;
  localparam logic [CNT_W-1:0] STROBE_LEN = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] GAP_LEN    = CNT_W'(GAP_CYC);
  // Read sample point: next-to-last cycle of the strobe
  localparam logic [CNT_W-1:0] SAMPLE_AT  = 4'h1;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'hFFFF;

  typedef enum logic [1:0] {
    CMD_CLAIM   = 2'h0,
    CMD_RELEASE = 2'h1,
    CMD_POLL    = 2'h2,
    CMD_INIT    = 2'h3
  } dps_cmd_e;

  // Port pins toward the device; the strobes are active low, d0_oe is active high
  typedef struct packed {
    logic             token_space_select_n;
    logic             oe_n;
    logic             rw_n;
    logic [IDX_W-1:0] flag_index_bits;
    logic             d0;
    logic             d0_oe;
  } dps_pins_s;
endpackage

/* hw/dps_sem_host.sv */
// Controller that claims, polls and releases semaphore flags over one port
// How it works
// - Claim writes zero then reads back
// - Failed claim polls or writes one
// - Drop select between repeated reads
// - Write one to all flags at init
`timescale 1ns/1ps
module dps_sem_host
  import dps_pkg::*;
(
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              SRST,
  // User command port
  input  wire logic              CMD_VALID,
  input  wire dps_cmd_e          CMD_OP,
  input  wire logic [IDX_W-1:0]  CMD_INDEX,
  input  wire logic              CMD_RETRY,
  output logic                   CMD_READY,
  output logic                   DONE,
  output logic                   GRANTED,
  // Device port pins
  output dps_pins_s              PINS,
  input  wire logic [DATA_W-1:0] DATA_IN
);

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_WRITE  = 6'b000010,
    ST_WGAP   = 6'b000100,
    ST_READ   = 6'b001000,
    ST_RGAP   = 6'b010000,
    ST_FINISH = 6'b100000
  } dps_state_e;

  dps_state_e        state_q;
  dps_cmd_e          op_q;
  logic [IDX_W-1:0]  idx_q;
  logic              retry_q;
  logic              wbit_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [IDX_W:0]    init_left_q;
  logic [DATA_W-1:0] din_s1_q, din_s2_q, din_s3_q;
  logic [DATA_W-1:0] din_ok_q;
  logic              owned;
  logic              cnt_zero;
  logic              take;
  logic              more_init;
  logic              write_end;
  logic              wgap_end;
  logic              read_end;
  logic              rgap_end;

  assign cnt_zero  = (cnt_q == '0);
  assign take      = (state_q == ST_IDLE) && CMD_VALID;
  assign more_init = (op_q == CMD_INIT) && (init_left_q != '0);
  assign write_end = (state_q == ST_WRITE) && cnt_zero;
  assign wgap_end  = (state_q == ST_WGAP) && cnt_zero;
  assign read_end  = (state_q == ST_READ) && cnt_zero;
  assign rgap_end  = (state_q == ST_RGAP) && cnt_zero;
  assign owned     = (din_ok_q == '0);

  // Pin data passes three stages
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      din_s1_q <= DATA_RST;
      din_s2_q <= DATA_RST;
      din_s3_q <= DATA_RST;
    end else begin
      din_s1_q <= DATA_IN;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
    end
  end

  // A new bus value counts once stages two and three agree
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      din_ok_q <= DATA_RST;
    end else if (din_s2_q == din_s3_q) begin
      din_ok_q <= din_s3_q;
    end
  end

  // Phase counter; each phase reloads it on entry
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cnt_q <= '0;
    end else if (take || wgap_end || rgap_end) begin
      cnt_q <= STROBE_LEN;
    end else if (write_end || read_end) begin
      cnt_q <= GAP_LEN;
    end else if (!cnt_zero) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // Sequencer
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (CMD_VALID) state_q <= (CMD_OP == CMD_POLL) ? ST_READ : ST_WRITE;
        end
        ST_WRITE: if (cnt_zero) state_q <= ST_WGAP;
        ST_WGAP: begin
          if (cnt_zero) begin
            if (more_init) begin
              state_q <= ST_WRITE;
            end else if (op_q == CMD_CLAIM) begin
              state_q <= ST_READ;
            end else begin
              state_q <= ST_FINISH;
            end
          end
        end
        ST_READ: if (cnt_zero) state_q <= ST_RGAP;
        ST_RGAP: begin
          if (cnt_zero) begin
            if (GRANTED || op_q == CMD_POLL) begin
              state_q <= ST_FINISH;
            end else if (retry_q) begin
              // keep polling; no bound, a flag never freed keeps us busy
              state_q <= ST_READ;
            end else begin
              state_q <= ST_WRITE;
            end
          end
        end
        ST_FINISH: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Command fields; a failed claim without retry turns into a release
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      op_q    <= CMD_POLL;
      retry_q <= 1'b0;
      wbit_q  <= 1'b1;
    end else if (take) begin
      op_q    <= CMD_OP;
      retry_q <= CMD_RETRY;
      wbit_q  <= (CMD_OP == CMD_CLAIM) ? 1'b0 : 1'b1;
    end else if (rgap_end && !GRANTED && op_q == CMD_CLAIM && !retry_q) begin
      op_q    <= CMD_RELEASE;
      wbit_q  <= 1'b1;
    end
  end

  // Flag index; init walks all eight flags
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      idx_q       <= '0;
      init_left_q <= '0;
    end else if (take) begin
      idx_q       <= (CMD_OP == CMD_INIT) ? '0 : CMD_INDEX;
      init_left_q <= (IDX_W+1)'(FLAG_COUNT - 1);
    end else if (wgap_end && more_init) begin
      idx_q       <= idx_q + 1'b1;
      init_left_q <= init_left_q - 1'b1;
    end
  end

  // Outcome of the last readback; write-only commands clear it
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      GRANTED <= 1'b0;
    end else if (state_q == ST_READ && cnt_q == SAMPLE_AT) begin
      // sample late in the latched read
      GRANTED <= owned;
    end else if (wgap_end && !more_init && op_q != CMD_CLAIM) begin
      GRANTED <= 1'b0;
    end
  end

  // Pin drive; array select never used, so array untouched
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PINS      <= '{token_space_select_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1,
                     flag_index_bits: '0, d0: 1'b1, d0_oe: 1'b0};
      CMD_READY <= 1'b0;
      DONE      <= 1'b0;
    end else begin
      // select low only during a strobe
      PINS.token_space_select_n <= !(state_q == ST_WRITE || state_q == ST_READ);
      PINS.oe_n                 <= (state_q != ST_READ);
      PINS.rw_n                 <= (state_q != ST_WRITE);
      PINS.flag_index_bits      <= idx_q;
      // only data bit zero is driven
      PINS.d0                   <= wbit_q;
      PINS.d0_oe                <= (state_q == ST_WRITE);
      CMD_READY                 <= (state_q == ST_IDLE) && !CMD_VALID;
      DONE                      <= (state_q == ST_FINISH);
    end
  end

endmodule // dps_sem_host

/* test/dps_sem_host_assertions.sv */
// Checker for the controller's pin sequencing
`timescale 1ns/1ps
module dps_sem_host_assertions
  import dps_pkg::*;
(
  input wire logic      CLOCK,
  input wire logic      SRST,
  input wire logic      CMD_VALID,
  input wire dps_cmd_e  CMD_OP,
  input wire logic      CMD_READY,
  input wire dps_pins_s PINS
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  AST_CLAIM_WRITES_ZERO:
    assert property (CMD_VALID && CMD_READY && CMD_OP == CMD_CLAIM |-> ##[1:4]
      (!PINS.token_space_select_n && !PINS.rw_n && !PINS.d0 && PINS.d0_oe))
      else $error("claim did not start with a zero write");
  AST_INIT_FLAG0_ONE:
    assert property (CMD_VALID && CMD_READY && CMD_OP == CMD_INIT |-> ##[1:4]
      (!PINS.token_space_select_n && !PINS.rw_n && PINS.d0 && PINS.flag_index_bits == 3'h0))
      else $error("init did not write one to flag zero");
  AST_SELECT_GAP:
    assert property ($rose(PINS.token_space_select_n) |-> PINS.token_space_select_n[*2])
      else $error("select gap shorter than two cycles");
  AST_READ_NO_DRIVE:
    assert property (!PINS.token_space_select_n && !PINS.oe_n |-> PINS.rw_n && !PINS.d0_oe)
      else $error("read strobe while driving data");
  cover property (CMD_VALID && CMD_READY && CMD_OP == CMD_CLAIM);
  cover property (CMD_VALID && CMD_READY && CMD_OP == CMD_POLL);
  cover property (CMD_VALID && CMD_READY && CMD_OP == CMD_RELEASE);
endmodule // dps_sem_host_assertions

bind dps_sem_host dps_sem_host_assertions chk_u (.CLOCK(CLOCK), .SRST(SRST),
  .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_READY(CMD_READY), .PINS(PINS));

/* test/dps_sem_dev.sv */
// Device model: eight flags, our side on pins, far side on plain strobes
`timescale 1ns/1ps
module dps_sem_dev
  import dps_pkg::*;
(
  input  wire logic             clock,
  input  wire dps_pins_s        pins,
  input  wire logic             b_wr,
  input  wire logic [IDX_W-1:0] b_idx,
  input  wire logic             b_d0,
  output logic [DATA_W-1:0]     data_out,
  output logic [FLAG_COUNT-1:0] own_b_q
);
  logic [FLAG_COUNT-1:0] req_a_q, req_b_q, own_a_q;
  logic                  rd_q, was_q;
  // select plus three index bits, no array
  wire a_wr = !pins.token_space_select_n && !pins.rw_n;
  wire a_rd = !pins.token_space_select_n && !pins.oe_n;
  wire live = !own_a_q[pins.flag_index_bits];
  always_ff @(posedge clock) begin
    if (a_wr) req_a_q[pins.flag_index_bits] <= pins.d0;
    if (b_wr) req_b_q[b_idx] <= b_d0;
  end
  // ownership, tie goes to our side
  always_ff @(posedge clock) begin
    for (int i = 0; i < FLAG_COUNT; i++) begin
      own_a_q[i] <= !req_a_q[i] && (own_a_q[i] || !own_b_q[i]);
      own_b_q[i] <= !req_b_q[i] && (own_b_q[i] || req_a_q[i]);
    end
  end
  // value held while both strobes stay low
  always_ff @(posedge clock) begin
    was_q <= a_rd;
    if (a_rd && !was_q) rd_q <= live;
  end
  // Idle bus shows the inverse so a stale value never passes
  assign data_out = {DATA_W{a_rd ? (was_q ? rd_q : live) : !rd_q}};
endmodule // dps_sem_dev

/* test/dps_sem_host_test.sv */
// Testbench for the semaphore port controller
`timescale 1ns/1ps
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("BAD %0t %h %h", $time, (a), (b)); \
  end \
end
module dps_sem_host_test
  import dps_pkg::*;
;
  logic                  clock = 1'b0, srst = 1'b1, valid = 1'b0, retry = 1'b0;
  logic                  b_wr = 1'b0, b_d0 = 1'b1;
  dps_cmd_e              op = CMD_POLL;
  logic [IDX_W-1:0]      index = '0, b_idx = '0;
  logic                  ready, done, granted;
  dps_pins_s             pins;
  logic [DATA_W-1:0]     data;
  logic [FLAG_COUNT-1:0] own_b;
  int                    errors = 0, total_checks = 0;
  dps_sem_host dut_u (.CLOCK(clock), .SRST(srst), .CMD_VALID(valid), .CMD_OP(op),
    .CMD_INDEX(index), .CMD_RETRY(retry), .CMD_READY(ready), .DONE(done),
    .GRANTED(granted), .PINS(pins), .DATA_IN(data));
  dps_sem_dev dev_u (.clock(clock), .pins(pins), .b_wr(b_wr), .b_idx(b_idx),
    .b_d0(b_d0), .data_out(data), .own_b_q(own_b));
  initial forever #5 clock = ~clock;
  task automatic conclude;
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  task automatic run(input dps_cmd_e o, input logic [IDX_W-1:0] i, input logic r, input logic g);
    int n;
    n = 0;
    while (!ready && n < 50) begin
      step();
      n++;
    end
    if (!ready) begin
      errors++;
      conclude();
    end
    valid = 1'b1;
    op = o;
    index = i;
    retry = r;
    step();
    valid = 1'b0;
    n = 0;
    while (!done && n < 300) begin
      step();
      n++;
    end
    if (!done) begin
      errors++;
      conclude();
    end else begin
      `CHK(granted, g)
    end
  endtask
  task automatic far(input logic [IDX_W-1:0] i, input logic d);
    b_idx = i;
    b_d0 = d;
    b_wr = 1'b1;
    step();
    b_wr = 1'b0;
    // Spare edge lets ownership settle and keeps strobes apart
    step();
  endtask
  initial begin
    repeat (8) @(posedge clock);
    #1 srst = 0;
    for (int i = 0; i < FLAG_COUNT; i++) far(i[IDX_W-1:0], 1'b1);
    run(CMD_INIT, 3'h0, 1'b0, 1'b0);
    run(CMD_CLAIM, 3'h5, 1'b0, 1'b1);
    far(3'h5, 1'b0);
    run(CMD_RELEASE, 3'h5, 1'b0, 1'b0);
    `CHK(own_b[5], 1'b1)
    run(CMD_CLAIM, 3'h5, 1'b0, 1'b0);
    far(3'h5, 1'b1);
    `CHK(own_b[5], 1'b0)
    run(CMD_POLL, 3'h5, 1'b0, 1'b0);
    far(3'h2, 1'b0);
    fork
      run(CMD_CLAIM, 3'h2, 1'b1, 1'b1);
      begin
        repeat (60) step();
        far(3'h2, 1'b1);
      end
    join
    run(CMD_POLL, 3'h2, 1'b0, 1'b1);
    conclude();
  end
endmodule // dps_sem_host_test
